// ==== bench/host_serial_command_port_bench.sv ====
// self-checking bench joining host and device ends of the serial command port
`timescale 1ns/1ps
`default_nettype none

module host_serial_command_port_bench;
    import hscp_pkg::*;

    // ==========================================================
    // stimulus and observed values
    logic        clk;
    logic        rst;
    logic        start;
    hscp_cmd_t   cmdKind;
    logic [7:0]  cmdAddr;
    logic [7:0]  cmdData;
    logic        readHit;
    logic [7:0]  replyByte;
    logic        standbyNoClock;
    logic        irqPending;
    logic        busy;
    logic        done;
    logic [7:0]  readByte;
    logic        interruptActive;
    logic [7:0]  addrByte;
    logic        addrStrobe;
    logic        wrStrobe;
    logic [7:0]  wrAddr;
    logic [7:0]  wrData;
    logic        generalReset;
    logic        oscillatorEnable;
    logic [7:0]  addrByteB;
    logic        addrStrobeB;
    logic        wrStrobeB;
    logic [7:0]  wrAddrB;
    logic [7:0]  wrDataB;
    logic        generalResetB;
    logic [23:0] wireShift;
    int          wireBits;
    int          nAddr, nWr, nGr, nAddrB, nWrB, nGrB;
    int          checks, mismatches, seed, i;

    hscp_if link ();
    hscp_if faultLink ();

    hscp_host i_hscp_host (.clk(clk), .rst(rst), .bus(link), .start(start), .cmdKind(cmdKind),
        .cmdAddr(cmdAddr), .cmdData(cmdData), .busy(busy), .done(done), .readByte(readByte),
        .interruptActive(interruptActive));
    hscp_device i_hscp_device (.clk(clk), .rst(rst), .bus(link), .addrByte(addrByte),
        .addrStrobe(addrStrobe), .readHit(readHit), .replyByte(replyByte), .wrStrobe(wrStrobe),
        .wrAddr(wrAddr), .wrData(wrData), .generalReset(generalReset),
        .standbyNoClock(standbyNoClock), .oscillatorEnable(oscillatorEnable),
        .irqPending(irqPending));
    // second device, driven by the bench so that frames can be broken on purpose
    hscp_device i_hscp_device_b (.clk(clk), .rst(rst), .bus(faultLink), .addrByte(addrByteB),
        .addrStrobe(addrStrobeB), .readHit(1'b0), .replyByte(8'h00), .wrStrobe(wrStrobeB),
        .wrAddr(wrAddrB), .wrData(wrDataB), .generalReset(generalResetB),
        .standbyNoClock(1'b0), .oscillatorEnable(), .irqPending(1'b0));
    hscp_chk i_hscp_chk (.clk(clk), .rst(rst), .serialClock(link.serialClock),
        .commandData(link.commandData), .busSelectLow(link.busSelectLow),
        .replyData(link.replyData), .replyDataOe(link.replyDataOe),
        .interruptRequestLowOe(link.interruptRequestLowOe));

    // ==========================================================
    // clock, strobe counters, wire sampler
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        nAddr += int'(addrStrobe === 1'b1);
        nWr += int'(wrStrobe === 1'b1);
        nGr += int'(generalReset === 1'b1);
        nAddrB += int'(addrStrobeB === 1'b1);
        nWrB += int'(wrStrobeB === 1'b1);
        nGrB += int'(generalResetB === 1'b1);
    end
    // bits as the wire carries them, sampled like the device does
    always @(posedge link.serialClock) begin
        if (link.busSelectLow === 1'b0) begin
            wireShift = {wireShift[22:0], link.commandData};
            wireBits++;
        end
    end

    // ==========================================================
    // expectations and comparison
    function automatic int exp_bits(input hscp_cmd_t kind);
        return (kind == HSCP_CMD_ADDR_ONLY) ? 8 : 16;
    endfunction : exp_bits
    function automatic int exp_resets(input hscp_cmd_t kind, input logic [7:0] addr);
        return int'(kind == HSCP_CMD_ADDR_ONLY && addr == 8'h01);
    endfunction : exp_resets

    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        checks++;
        if (seen !== expected) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask : check

    // one host command; a second start mid-transfer must be ignored
    task automatic run_cmd(input hscp_cmd_t kind, input logic [7:0] addr,
                           input logic [7:0] data, input logic [7:0] reply);
        int a0, w0, g0, n;
        logic irq, stby;
        a0 = nAddr;
        w0 = nWr;
        g0 = nGr;
        irq = 1'($random(seed));
        stby = 1'($random(seed));
        @(negedge clk);
        cmdKind = kind;
        {cmdAddr, cmdData, replyByte} = {addr, data, reply};
        readHit = (kind == HSCP_CMD_READ);
        irqPending = irq;
        standbyNoClock = stby;
        wireBits = 0;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (20) @(negedge clk);
        check(16'(busy), 16'h0001);
        start = 1'b1;
        cmdAddr = ~addr;
        @(negedge clk);
        start = 1'b0;
        for (n = 0; n < 400 && done !== 1'b1; n++) @(negedge clk);
        check(16'(done), 16'h0001);
        check(16'(busy), 16'h0000);
        repeat (8) @(negedge clk);
        check(16'(addrByte), 16'(addr));
        check(16'(nAddr - a0), 16'h0001);
        check(16'(nWr - w0), 16'(kind == HSCP_CMD_WRITE));
        if (kind == HSCP_CMD_WRITE) check({wrAddr, wrData}, {addr, data});
        if (kind == HSCP_CMD_WRITE) check(16'(wireShift[7:0]), 16'(data));
        if (kind == HSCP_CMD_READ) check(16'(readByte), 16'(reply));
        check(16'(nGr - g0), 16'(exp_resets(kind, addr)));
        check(16'(wireBits), 16'(exp_bits(kind)));
        check(16'(exp_bits(kind) == 8 ? wireShift[7:0] : wireShift[15:8]), 16'(addr));
        check(16'(link.replyLevel), 16'h0001);
        check(16'(oscillatorEnable), 16'(!stby));
        check(16'(link.interruptRequestLow), 16'(!irq));
        check(16'(interruptActive), 16'(irq));
    endtask : run_cmd

    // bench as host on the second link, n bits MSB first then deselect
    task automatic fault_frame(input logic [23:0] bits, input int n);
        int k;
        @(negedge clk);
        faultLink.busSelectLow = 1'b0;
        repeat (4) @(negedge clk);
        for (k = 0; k < n; k++) begin
            faultLink.serialClock = 1'b0;
            faultLink.commandData = bits[23 - k];
            repeat (4) @(negedge clk);
            faultLink.serialClock = 1'b1;
            repeat (4) @(negedge clk);
        end
        faultLink.busSelectLow = 1'b1;
        // released line shows the inverse so a stale level is never trusted
        faultLink.commandData = ~faultLink.commandData;
        repeat (8) @(negedge clk);
    endtask : fault_frame

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    // ==========================================================
    // watchdog, far above the roughly 2500 cycles the run needs
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        give_verdict();
    end

    // ==========================================================
    // main sequence
    initial begin
        {checks, mismatches, wireBits, wireShift} = {32'h0, 32'h0, 32'h0, 24'h000000};
        seed = 16131;
        {nAddr, nWr, nGr, nAddrB, nWrB, nGrB} = '0;
        {rst, start, readHit, standbyNoClock, irqPending} = 5'b10000;
        cmdKind = HSCP_CMD_ADDR_ONLY;
        {cmdAddr, cmdData, replyByte} = 24'h000000;
        {faultLink.serialClock, faultLink.busSelectLow, faultLink.commandData} = 3'b110;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        check(16'(link.replyLevel), 16'h0001);
        run_cmd(HSCP_CMD_ADDR_ONLY, 8'h01, 8'h00, 8'h00);
        run_cmd(HSCP_CMD_WRITE, 8'h01, 8'hFF, 8'h00);
        run_cmd(HSCP_CMD_READ, 8'hFF, 8'h00, 8'h81);
        run_cmd(HSCP_CMD_ADDR_ONLY, 8'h00, 8'h00, 8'h00);
        for (i = 0; i < 12; i++) begin
            run_cmd(hscp_cmd_t'(2'($unsigned($random(seed)) % 3)), 8'($random(seed)),
                    8'($random(seed)), 8'($random(seed)));
        end
        fault_frame(24'hFF0000, 5);
        check(16'(nAddrB), 16'h0000);
        fault_frame(24'h5A0000, 8);
        check({addrByteB, 8'(nAddrB)}, 16'h5A01);
        check(16'(nGrB), 16'h0000);
        fault_frame(24'h010000, 8);
        check(16'(nGrB), 16'h0001);
        fault_frame(24'hA53CFF, 24);
        check({8'(nWrB), 8'(nGrB)}, 16'h0101);
        check({wrAddrB, wrDataB}, 16'hA53C);
        fault_frame(24'h77F000, 12);
        check({addrByteB, 8'(nWrB)}, 16'h7701);
        check(16'(faultLink.replyLevel), 16'h0001);
        give_verdict();
    end
endmodule : host_serial_command_port_bench

`default_nettype wire

// ==== bench/hscp_chk.sv ====
// concurrent checks on the pins between host and device ends
`timescale 1ns/1ps
`default_nettype none

module hscp_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link pins
    input wire logic serialClock,
    input wire logic commandData,
    input wire logic busSelectLow,
    input wire logic replyData,
    input wire logic replyDataOe,
    input wire logic interruptRequestLowOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ==========================================================
    // helper: serial clock rises within one frame
    logic       sclkPrev_q;
    logic [4:0] riseCount_q;

    // previous clock level for edge finding
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclkPrev_q <= 1'b1;
        end else begin
            sclkPrev_q <= serialClock;
        end
    end

    // cleared while deselected so an aborted frame cannot leak into the next
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            riseCount_q <= 5'h00;
        end else if (busSelectLow) begin
            riseCount_q <= 5'h00;
        end else if (serialClock && !sclkPrev_q) begin
            riseCount_q <= riseCount_q + 5'h01;
        end
    end

    // ==========================================================
    // assertions
    frame_bits_a: assert property ($rose(busSelectLow) |->
        riseCount_q == 5'h08 || riseCount_q == 5'h10)
        else $error("frame closed with a bit count other than 8 or 16");
    reply_gated_a: assert property (replyDataOe && !busSelectLow |-> riseCount_q >= 5'h08)
        else $error("reply driven before the address byte completed");
    reply_release_a: assert property ($rose(busSelectLow) |-> ##[0:5] !replyDataOe)
        else $error("reply pin still driven after deselect");
    sclk_idle_a: assert property (busSelectLow |-> serialClock)
        else $error("serial clock not high while deselected");
    cmd_stable_a: assert property (!busSelectLow && $past(!busSelectLow) && serialClock
        && $past(serialClock) |-> $stable(commandData))
        else $error("command data moved while serial clock high");
    reply_stable_a: assert property (replyDataOe && $past(replyDataOe) && serialClock
        && $past(serialClock) |-> $stable(replyData))
        else $error("reply bit moved while serial clock high");
    half_period_a: assert property ($fell(serialClock) |-> !serialClock [*4] ##1 serialClock)
        else $error("serial clock low phase not four cycles");
    select_setup_a: assert property ($fell(busSelectLow) |->
        serialClock [*4] ##1 !serialClock)
        else $error("first serial clock fall not four cycles after select");

    // ==========================================================
    // main scenarios
    cover property ($rose(busSelectLow) && riseCount_q == 5'h08);
    cover property ($rose(busSelectLow) && riseCount_q == 5'h10);
    cover property ($rose(replyDataOe));
    cover property ($rose(interruptRequestLowOe));
endmodule : hscp_chk

`default_nettype wire

// ==== hw/hscp_device.sv ====
// device end of the serial command port: deserialiser, reply shifter, pins
`timescale 1ns/1ps
`default_nettype none

// Operation
// (R1) address byte, then at most one byte
// (R2) command bits taken on serial clock rise
// (R3) reply bit valid during clock high
// (R4) lone address 01 means general reset
// (R5) standby no-clock stops the oscillator
// (R6) host selects standby while clock absent
// (R7) eight bit bytes, most significant first
// (R8) reply pin released when not replying
// (R9) active low select frames every transfer
// (R10) interrupt pulls low, else released
// (R11) select high drops partial byte
module hscp_device (
    // clock and reset
    input  wire logic  clk,
    input  wire logic  rst,
    // pins toward the host
    hscp_if.device     bus,
    // address phase
    output logic [7:0] addrByte,
    output logic       addrStrobe,
    input  wire logic  readHit,
    input  wire logic [7:0] replyByte,
    // write phase
    output logic       wrStrobe,
    output logic [7:0] wrAddr,
    output logic [7:0] wrData,
    // control
    output logic       generalReset,
    input  wire logic  standbyNoClock,
    output logic       oscillatorEnable,
    input  wire logic  irqPending
);
    import hscp_pkg::*;

    // ==========================================================
    // pin synchronisers
    logic [2:0] sclkSync_q;
    logic [1:0] dataSync_q;
    logic [2:0] selSync_q;
    logic       sclkRise;
    logic       sclkFall;
    logic       selActive;
    logic       selRise;
    logic [7:0] shiftNext;

    // stage 0 feeds stage 1 only; stage 2 is the edge history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclkSync_q <= 3'h7;                                // idle high, no false edge
            dataSync_q <= 2'h0;
            selSync_q  <= 3'h7;
        end else begin
            sclkSync_q <= {sclkSync_q[1:0], bus.serialClock};
            dataSync_q <= {dataSync_q[0], bus.commandData};
            selSync_q  <= {selSync_q[1:0], bus.busSelectLow};
        end
    end

    // edges seen on the synchronised copies, data delayed alike
    assign sclkRise  = sclkSync_q[1] & ~sclkSync_q[2];
    assign sclkFall  = ~sclkSync_q[1] & sclkSync_q[2];
    assign selActive = ~selSync_q[1];                          // R9
    assign selRise   = selSync_q[1] & ~selSync_q[2];

    // ==========================================================
    // receive shifter and bit counter
    logic [7:0] shift_q;
    logic [4:0] bitCnt_q;
    logic       readMode_q;

    assign shiftNext = {shift_q[6:0], dataSync_q[1]};         // R7

    // count saturates after two bytes so extra clocks do nothing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_q  <= 8'h00;
            bitCnt_q <= 5'h00;
        end else if (!selActive) begin
            shift_q  <= 8'h00;                                 // R11
            bitCnt_q <= 5'h00;                                 // R11
        end else if (sclkRise && bitCnt_q != FRAME_BITS) begin // R1
            shift_q  <= shiftNext;                             // R2
            bitCnt_q <= bitCnt_q + 5'h01;
        end
    end

    // ==========================================================
    // address capture
    logic [7:0] addrByte_q;
    logic       addrStrobe_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addrByte_q   <= 8'h00;
            addrStrobe_q <= 1'b0;
        end else begin
            addrStrobe_q <= 1'b0;
            if (selActive && sclkRise && bitCnt_q == ADDR_BITS - 5'h01) begin
                addrByte_q   <= shiftNext;                     // R7
                addrStrobe_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // write capture, only when the second byte came from the host
    logic       wrStrobe_q;
    logic [7:0] wrAddr_q;
    logic [7:0] wrData_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrStrobe_q <= 1'b0;
            wrAddr_q   <= 8'h00;
            wrData_q   <= 8'h00;
        end else begin
            wrStrobe_q <= 1'b0;
            if (selActive && sclkRise && !readMode_q &&
                bitCnt_q == FRAME_BITS - 5'h01) begin       // R1
                wrStrobe_q <= 1'b1;
                wrAddr_q   <= addrByte_q;
                wrData_q   <= shiftNext;
            end
        end
    end

    // ==========================================================
    // general reset: address 01 closed with no second byte begun
    logic generalReset_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            generalReset_q <= 1'b0;
        end else begin
            generalReset_q <= selRise && bitCnt_q == ADDR_BITS &&
                              addrByte_q == RESET_CMD_ADDR;    // R4
        end
    end

    // ==========================================================
    // reply shifter; bits change on the fall so they hold while high
    logic [7:0] replyShift_q;
    logic [2:0] replyCnt_q;
    logic       replyData_q;
    logic       replyOe_q;

    // the read decision is taken at the first fall after the address,
    // so the user side has about half a serial period to answer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            replyShift_q <= 8'h00;
            replyCnt_q   <= 3'h0;
            replyData_q  <= 1'b0;
            replyOe_q    <= 1'b0;
            readMode_q   <= 1'b0;
        end else if (!selActive) begin
            replyOe_q    <= 1'b0;                              // R8
            readMode_q   <= 1'b0;
            replyCnt_q   <= 3'h0;
        end else if (sclkFall) begin
            if (!readMode_q && bitCnt_q == ADDR_BITS && readHit) begin
                readMode_q   <= 1'b1;                          // R1
                replyOe_q    <= 1'b1;
                replyData_q  <= replyByte[7];                  // R3
                replyShift_q <= {replyByte[6:0], 1'b0};
                replyCnt_q   <= 3'h0;
            end else if (replyOe_q) begin
                if (replyCnt_q == LAST_REPLY_BIT) begin
                    replyOe_q   <= 1'b0;                       // R8
                end else begin
                    replyData_q  <= replyShift_q[7];           // R3
                    replyShift_q <= {replyShift_q[6:0], 1'b0};
                    replyCnt_q   <= replyCnt_q + 3'h1;
                end
            end
        end
    end

    // ==========================================================
    // interrupt and oscillator control
    logic irqOe_q;
    logic oscEnable_q;

    // the oscillator may lag standby by one cycle; harmless for power
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqOe_q     <= 1'b0;
            oscEnable_q <= OSC_EN_RESET;
        end else begin
            irqOe_q     <= irqPending;                         // R10
            oscEnable_q <= ~standbyNoClock;                    // R5
        end
    end

    // ==========================================================
    // outputs, all from flip-flops
    assign bus.replyData             = replyData_q;
    assign bus.replyDataOe           = replyOe_q;              // R8
    assign bus.interruptRequestLowOe = irqOe_q;                // R10
    assign addrByte                  = addrByte_q;
    assign addrStrobe                = addrStrobe_q;
    assign wrStrobe                  = wrStrobe_q;
    assign wrAddr                    = wrAddr_q;
    assign wrData                    = wrData_q;
    assign generalReset              = generalReset_q;
    assign oscillatorEnable          = oscEnable_q;

endmodule : hscp_device

`default_nettype wire

// ==== hw/hscp_host.sv ====
// host end of the serial command port: clock divider and transfer sequencer
`timescale 1ns/1ps
`default_nettype none

module hscp_host (
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rst,
    // pins toward the device
    hscp_if.host           bus,
    // command request
    input  wire logic      start,
    input  wire hscp_pkg::hscp_cmd_t cmdKind,
    input  wire logic [7:0] cmdAddr,
    input  wire logic [7:0] cmdData,
    // command result
    output logic           busy,
    output logic           done,
    output logic [7:0]     readByte,
    output logic           interruptActive
);
    import hscp_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE,
        H_SETUP,
        H_LOW,
        H_HIGH,
        H_HOLD
    } hscp_hstate_t;

    // ==========================================================
    // pin synchronisers
    logic [1:0] replySync_q;
    logic [1:0] irqSync_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            replySync_q <= 2'h3;
            irqSync_q   <= 2'h3;
        end else begin
            replySync_q <= {replySync_q[0], bus.replyLevel};
            irqSync_q   <= {irqSync_q[0], bus.interruptRequestLow};
        end
    end

    // ==========================================================
    // half period divider, restarted on each accepted command
    hscp_hstate_t state_q;
    logic [3:0]   halfCnt_q;
    logic         tick;

    assign tick = (halfCnt_q == 4'h0);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            halfCnt_q <= 4'h0;
        end else if (state_q == H_IDLE || tick) begin
            halfCnt_q <= SCLK_HALF_CYCLES - 4'h1;
        end else begin
            halfCnt_q <= halfCnt_q - 4'h1;
        end
    end

    // ==========================================================
    // transfer sequencer; clock idles high, data changes on the fall
    logic        sclk_q;
    logic        sel_q;
    logic        cmdOut_q;
    logic [15:0] txShift_q;
    logic [4:0]  bitsLeft_q;
    logic [7:0]  rxShift_q;
    logic        isRead_q;
    logic        busy_q;
    logic        done_q;
    logic [7:0]  readByte_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q    <= H_IDLE;
            sclk_q     <= PIN_IDLE_HIGH;
            sel_q      <= PIN_IDLE_HIGH;
            cmdOut_q   <= 1'b0;
            txShift_q  <= 16'h0000;
            bitsLeft_q <= 5'h00;
            rxShift_q  <= 8'h00;
            isRead_q   <= 1'b0;
            busy_q     <= 1'b0;
            done_q     <= 1'b0;
            readByte_q <= 8'h00;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                H_IDLE: begin
                    if (start) begin
                        sel_q      <= 1'b0;                    // R9
                        busy_q     <= 1'b1;
                        isRead_q   <= (cmdKind == HSCP_CMD_READ);
                        txShift_q  <= {cmdAddr, (cmdKind == HSCP_CMD_WRITE) ? cmdData : 8'h00};
                        bitsLeft_q <= (cmdKind == HSCP_CMD_ADDR_ONLY) ?
                                      ADDR_BITS : FRAME_BITS;  // R1 R4
                        state_q    <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    if (tick) begin
                        sclk_q    <= 1'b0;
                        cmdOut_q  <= txShift_q[15];            // R7
                        txShift_q <= {txShift_q[14:0], 1'b0};
                        state_q   <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (tick) begin
                        sclk_q  <= 1'b1;
                        state_q <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (tick) begin
                        // last cycle of the high phase: reply is settled
                        if (isRead_q && bitsLeft_q <= ADDR_BITS) begin
                            rxShift_q <= {rxShift_q[6:0], replySync_q[1]}; // R3
                        end
                        bitsLeft_q <= bitsLeft_q - 5'h01;
                        if (bitsLeft_q == 5'h01) begin
                            state_q <= H_HOLD;
                        end else begin
                            sclk_q    <= 1'b0;
                            cmdOut_q  <= txShift_q[15];        // R7
                            txShift_q <= {txShift_q[14:0], 1'b0};
                            state_q   <= H_LOW;
                        end
                    end
                end
                H_HOLD: begin
                    if (tick) begin
                        sel_q      <= 1'b1;                    // R9
                        cmdOut_q   <= 1'b0;
                        busy_q     <= 1'b0;
                        done_q     <= 1'b1;
                        readByte_q <= rxShift_q;
                        state_q    <= H_IDLE;
                    end
                end
                default: begin
                    state_q <= H_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // interrupt seen by the host, registered
    logic irqActive_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqActive_q <= 1'b0;
        end else begin
            irqActive_q <= ~irqSync_q[1];
        end
    end

    assign bus.serialClock  = sclk_q;
    assign bus.commandData  = cmdOut_q;
    assign bus.busSelectLow = sel_q;
    assign busy             = busy_q;
    assign done             = done_q;
    assign readByte         = readByte_q;
    assign interruptActive  = irqActive_q;

endmodule : hscp_host

`default_nettype wire

// ==== hw/hscp_if.sv ====
// pins between the host and the device of the serial command port
`timescale 1ns/1ps
`default_nettype none

interface hscp_if;
    // ==========================================================
    // host driven pins
    logic serialClock;
    logic commandData;
    logic busSelectLow;
    // device driven pins, three-state and open drain as data plus enable
    logic replyData;
    logic replyDataOe;
    logic interruptRequestLowOe;
    // resolved wire levels, pull-ups modelled as a high default
    logic replyLevel;
    logic interruptRequestLow;

    assign replyLevel          = replyDataOe ? replyData : 1'b1;
    assign interruptRequestLow = interruptRequestLowOe ? 1'b0 : 1'b1;

    modport device (
        input  serialClock,
        input  commandData,
        input  busSelectLow,
        output replyData,
        output replyDataOe,
        output interruptRequestLowOe
    );

    modport host (
        output serialClock,
        output commandData,
        output busSelectLow,
        input  replyLevel,
        input  interruptRequestLow
    );
endinterface : hscp_if

`default_nettype wire

// ==== hw/hscp_pkg.sv ====
// shared constants and types for the host serial command port
package hscp_pkg;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS  = 20;
    localparam int SCLK_PERIOD_NS = 160;
    // half a serial clock period in system clocks, never below one
    localparam int SCLK_HALF_INT  = (SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS)) < 1 ? 1 :
                                    (SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS));
    localparam logic [3:0] SCLK_HALF_CYCLES = 4'(SCLK_HALF_INT);

    // ==========================================================
    // framing
    localparam logic [4:0] ADDR_BITS      = 5'h08;
    localparam logic [4:0] FRAME_BITS     = 5'h10;
    localparam logic [2:0] LAST_REPLY_BIT = 3'h7;
    localparam logic [7:0] RESET_CMD_ADDR = 8'h01;

    // ==========================================================
    // reset values
    localparam logic       OSC_EN_RESET   = 1'b1;
    localparam logic       PIN_IDLE_HIGH  = 1'b1;

    // ==========================================================
    // transaction kinds requested by the host user side
    typedef enum logic [1:0] {
        HSCP_CMD_ADDR_ONLY,
        HSCP_CMD_WRITE,
        HSCP_CMD_READ
    } hscp_cmd_t;

endpackage : hscp_pkg
